// file: sdmlk_top.sv
// modulator configuration, self test and lock detect top
// Overview of operation
// R1: seed code picks zero, lsb, or one of two fixed 24-bit seeds.
// R2: seed writes are stored, loaded only on frequency change with auto seed load.
// R3: order field picks first order, second order, type 1 B, type 2 A.
// R4: bypass set divides by the integer value only, ignoring the modulator.
// R5: bypassed modulator keeps stepping while its reset-release input is high.
// R6: auto seed load reloads seed on each fractional write; else state continues.
// R7: test select chooses VCO divider or reference clock unless overridden.
// R8: clock select bit chooses auxiliary clock or delayed VCO clock.
// R9: frac_core_enable low disables the core, high enables it.
// R10: frac_core_enable picks integer or fractional write as calibration start.
// R11: setting self_test_enable starts the built-in self test.
// R12: self test runs 1032, 2047, 3071 or 4095 reference cycles.
// R13: software clears auto clock config above 50 MHz; bit resets to one.
// R14: lock declared after the programmed number of consecutive in-window comparisons.
// R15: window type picks digital timer or external analog one-shot.
// R16: digital window is half a cycle or 1 to 64 timer cycles.
// R17: two-bit field sets timer clock rate, fastest to slowest.
// R18: timer test bit keeps the timer clock running continuously.
// R19: auto relock makes exactly one relock attempt after lock fails.
// R20: fractional value is a 24-bit unsigned fraction of two to the 24.
// R21: a miss restarts the tally and drops lock status.
module sdmlk_top
  import sdmlk_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic [REG_AW-1:0] reg_addr_i,
  input wire logic [REG_DW-1:0] reg_wdata_i,
  output logic [REG_DW-1:0] reg_rdata_o,
  // frequency value writes
  input wire logic [18:0] intg_value_i,
  input wire logic [23:0] frac_value_i,
  input wire logic intg_write_i,
  input wire logic frac_write_i,
  // clocks and analog pins
  input wire logic ref_div_clk_i,
  input wire logic vco_div_clk_i,
  input wire logic vco_dly_clk_i,
  input wire logic aux_clk_i,
  input wire logic analog_win_i,
  input wire logic mod_rstb_i,
  // modulator outputs
  output logic [19:0] div_value_o,
  output logic frac_core_en_o,
  output logic [1:0] mod_clk_src_o,
  output logic cal_start_o,
  // lock detect outputs
  output logic lock_detect_o,
  output logic relock_o,
  // self test outputs
  output logic self_test_busy_o,
  output logic self_test_done_o,
  output logic [15:0] self_test_sig_o
);

  typedef struct packed {
    logic [23:0] mcfg;
    logic [23:0] lcfg;
    logic [23:0] rdata;
    logic [PIN_N-1:0] sync1;
    logic [PIN_N-1:0] sync2;
    logic [3:0] prev;
    sdmlk_clk_src_type clk_src;
    logic bist_en_prev;
    logic bist_busy;
    logic bist_done;
    logic [11:0] bist_cnt;
    logic [15:0] bist_sig;
  } sdmlk_top_state_type;

  sdmlk_top_state_type state_reg, state_next;
  sdmlk_core_if core();
  logic [3:0] rise;
  logic mod_tick;
  logic run;

  // ==========================================================
  // pin edges and modulator clocking
  assign rise = state_reg.sync2[3:0] & ~state_reg.prev;
  assign mod_tick = rise[state_reg.clk_src];
  // bypass does not stop the modulator
  assign run = state_reg.mcfg[CORE_EN_BIT] && state_reg.sync2[PIN_RSTB]; // R5 R9

  // ==========================================================
  // state update
  always_comb begin
    state_next = state_reg;
    state_next.sync1 = {mod_rstb_i, analog_win_i, aux_clk_i, vco_dly_clk_i,
                        vco_div_clk_i, ref_div_clk_i};
    state_next.sync2 = state_reg.sync1;
    state_next.prev = state_reg.sync2[3:0];
    if (reg_wr_i && reg_addr_i == MCFG_ADDR) begin
      state_next.mcfg = reg_wdata_i; // R2
    end
    if (reg_wr_i && reg_addr_i == LCFG_ADDR) begin
      state_next.lcfg = reg_wdata_i;
    end
    if (reg_addr_i == MCFG_ADDR) begin
      state_next.rdata = state_reg.mcfg;
    end else if (reg_addr_i == LCFG_ADDR) begin
      state_next.rdata = state_reg.lcfg;
    end else begin
      state_next.rdata = 24'h000000;
    end
    if (state_reg.mcfg[DLYCLK_SEL_BIT] || state_reg.mcfg[AUTOCLK_BIT]) begin // R7
      state_next.clk_src = state_reg.mcfg[DLYCLK_SEL_BIT] ? SDMLK_SRC_DLY
                                                          : SDMLK_SRC_AUX; // R8
    end else begin
      state_next.clk_src = state_reg.mcfg[REFDIV_SEL_BIT] ? SDMLK_SRC_VCO
                                                          : SDMLK_SRC_REF; // R7
    end
    // self test: run length counted in reference divider edges
    state_next.bist_en_prev = state_reg.mcfg[BIST_EN_BIT];
    if (state_reg.mcfg[BIST_EN_BIT] && !state_reg.bist_en_prev) begin // R11
      state_next.bist_busy = 1'b1;
      state_next.bist_done = 1'b0;
      state_next.bist_cnt = bist_len(state_reg.mcfg[BIST_CYC_LSB +: 2]); // R12
      state_next.bist_sig = 16'hFFFF;
    end else if (state_reg.bist_busy) begin
      if (mod_tick && run) begin
        state_next.bist_sig = {state_reg.bist_sig[14:0],
                               state_reg.bist_sig[15] ^ state_reg.bist_sig[13] ^
                               state_reg.bist_sig[12] ^ state_reg.bist_sig[10]}
                              ^ {13'h0000, core.offset};
      end
      if (rise[PIN_REF]) begin
        if (state_reg.bist_cnt == 12'h001) begin
          state_next.bist_busy = 1'b0;
          state_next.bist_done = 1'b1;
        end
        state_next.bist_cnt = state_reg.bist_cnt - 12'h001;
      end
    end else if (!state_reg.mcfg[BIST_EN_BIT]) begin
      state_next.bist_done = 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.mcfg <= MCFG_RESET; // R13
      state_reg.lcfg <= LCFG_RESET;
      state_reg.clk_src <= SDMLK_SRC_AUX;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // modulator hookup
  assign core.step = mod_tick && run;
  assign core.clear = !state_reg.sync2[PIN_RSTB];
  assign core.seed_load = frac_write_i && state_reg.mcfg[AUTO_SEED_LOAD_BIT]; // R6
  assign core.seed_value = seed_of(state_reg.mcfg[SEED_LSB +: 2]); // R1
  assign core.order = state_reg.mcfg[ORDER_LSB +: 2]; // R3
  assign core.bypass = state_reg.mcfg[BYPASS_BIT]; // R4
  assign core.frac_value = frac_value_i;
  assign core.intg_value = intg_value_i;

  sdmlk_modulator u_modulator (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .core(core.mod_mp)
  );

  // ==========================================================
  // lock detector hookup
  assign core.ref_ev = rise[PIN_REF];
  assign core.vco_ev = rise[PIN_VCO];
  assign core.win_in = state_reg.sync2[PIN_WIN];
  assign core.ld_enable = state_reg.lcfg[LD_EN_BIT];
  assign core.wincnt_code = state_reg.lcfg[WINCNT_LSB +: 3];
  assign core.win_digital = state_reg.lcfg[WIN_TYPE_BIT];
  assign core.win_dur = state_reg.lcfg[WIN_DUR_LSB +: 3];
  assign core.tmr_freq = state_reg.lcfg[TMR_FREQ_LSB +: 2];
  assign core.tmr_test = state_reg.lcfg[TMR_TEST_BIT];
  assign core.relock_en = state_reg.lcfg[RELOCK_BIT];

  sdmlk_lock_det u_lock_det (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .core(core.ld_mp)
  );

  // ==========================================================
  // outputs
  assign reg_rdata_o = state_reg.rdata;
  assign div_value_o = core.div_value;
  assign frac_core_en_o = state_reg.mcfg[CORE_EN_BIT]; // R9
  assign mod_clk_src_o = state_reg.clk_src;
  assign cal_start_o = state_reg.mcfg[CORE_EN_BIT] ? frac_write_i : intg_write_i; // R10
  assign lock_detect_o = core.locked;
  assign relock_o = core.relock_req;
  assign self_test_busy_o = state_reg.bist_busy;
  assign self_test_done_o = state_reg.bist_done;
  assign self_test_sig_o = state_reg.bist_sig;

  // ==========================================================
  // checks
  property p_cal_source;
    @(posedge clock_i) disable iff (rst_i)
    (frac_write_i && !intg_write_i) |-> (cal_start_o == state_reg.mcfg[CORE_EN_BIT]);
  endproperty
  a_cal_source: assert property (p_cal_source) // R10
    else $error("calibration start does not follow core enable");

  property p_bist_start;
    @(posedge clock_i) disable iff (rst_i)
    $rose(state_reg.mcfg[BIST_EN_BIT]) |=> ##1 self_test_busy_o;
  endproperty
  a_bist_start: assert property (p_bist_start) // R11
    else $error("self test did not start");

  property p_bist_len;
    @(posedge clock_i) disable iff (rst_i)
    $rose(self_test_busy_o)
      |-> (state_reg.bist_cnt == bist_len($past(state_reg.mcfg[BIST_CYC_LSB +: 2])));
  endproperty
  a_bist_len: assert property (p_bist_len) // R12
    else $error("self test length does not match the cycle code");

  property p_dly_override;
    @(posedge clock_i) disable iff (rst_i)
    state_reg.mcfg[DLYCLK_SEL_BIT] |=> (mod_clk_src_o == SDMLK_SRC_DLY);
  endproperty
  a_dly_override: assert property (p_dly_override) // R8
    else $error("delayed clock select was not honoured");

  property p_auto_override;
    @(posedge clock_i) disable iff (rst_i)
    (state_reg.mcfg[AUTOCLK_BIT] && !state_reg.mcfg[DLYCLK_SEL_BIT])
      |=> (mod_clk_src_o == SDMLK_SRC_AUX);
  endproperty
  a_auto_override: assert property (p_auto_override) // R7
    else $error("auto clock config did not override the test select");

  c_locked: cover property (@(posedge clock_i) disable iff (rst_i) $rose(lock_detect_o));
  c_relock: cover property (@(posedge clock_i) disable iff (rst_i) relock_o);
  c_bist_done: cover property (@(posedge clock_i) disable iff (rst_i) $rose(self_test_done_o));
  c_seed_load: cover property (@(posedge clock_i) disable iff (rst_i) core.seed_load);

endmodule // sdmlk_top

// file: sdmlk_pkg.sv
// shared constants, field positions and types of the modulator config and lock detect block
package sdmlk_pkg;

  // ==========================================================
  // register port
  localparam int REG_AW = 5;
  localparam int REG_DW = 24;
  localparam logic [4:0] MCFG_ADDR = 5'h06;
  localparam logic [4:0] LCFG_ADDR = 5'h07;
  localparam logic [23:0] MCFG_RESET = 24'h200B4A;
  localparam logic [23:0] LCFG_RESET = 24'h00014D;

  // ==========================================================
  // modulator_config fields
  localparam int SEED_LSB = 0;
  localparam int ORDER_LSB = 2;
  localparam int BYPASS_BIT = 7;
  localparam int AUTO_SEED_LOAD_BIT = 8;
  localparam int REFDIV_SEL_BIT = 9;
  localparam int DLYCLK_SEL_BIT = 10;
  localparam int CORE_EN_BIT = 11;
  localparam int BIST_EN_BIT = 18;
  localparam int BIST_CYC_LSB = 19;
  localparam int AUTOCLK_BIT = 21;

  // ==========================================================
  // lock_detect_config fields
  localparam int WINCNT_LSB = 0;
  localparam int LD_EN_BIT = 3;
  localparam int WIN_TYPE_BIT = 6;
  localparam int WIN_DUR_LSB = 7;
  localparam int TMR_FREQ_LSB = 10;
  localparam int TMR_TEST_BIT = 12;
  localparam int RELOCK_BIT = 13;

  // ==========================================================
  // seeds and counts
  localparam logic [23:0] SEED_ZERO = 24'h000000;
  localparam logic [23:0] SEED_ONE = 24'h000001;
  localparam logic [23:0] SEED_FIX_A = 24'hB29D08;
  localparam logic [23:0] SEED_FIX_B = 24'h50F1CD;
  localparam logic [15:0] LOCK_CNT_MAX = 16'hFFFF;

  // ==========================================================
  // synchronised pin lanes; the first four are also clock sources
  localparam int PIN_N = 6;
  localparam int PIN_REF = 0;
  localparam int PIN_VCO = 1;
  localparam int PIN_DLY = 2;
  localparam int PIN_AUX = 3;
  localparam int PIN_WIN = 4;
  localparam int PIN_RSTB = 5;

  typedef enum logic [1:0] {
    SDMLK_SRC_REF = 2'h0,
    SDMLK_SRC_VCO = 2'h1,
    SDMLK_SRC_DLY = 2'h2,
    SDMLK_SRC_AUX = 2'h3
  } sdmlk_clk_src_type;

  typedef enum logic [1:0] {
    SDMLK_ORD_FIRST = 2'h0,
    SDMLK_ORD_SECOND = 2'h1,
    SDMLK_ORD_T1B = 2'h2,
    SDMLK_ORD_T2A = 2'h3
  } sdmlk_order_type;

  typedef enum logic {
    SDMLK_LD_IDLE = 1'b0,
    SDMLK_LD_OPEN = 1'b1
  } sdmlk_ld_phase_type;

  function automatic logic [23:0] seed_of(input logic [1:0] code);
    unique case (code)
      2'h0: seed_of = SEED_ZERO;
      2'h1: seed_of = SEED_ONE;
      2'h2: seed_of = SEED_FIX_A;
      2'h3: seed_of = SEED_FIX_B;
    endcase
  endfunction

  function automatic logic [11:0] bist_len(input logic [1:0] code);
    unique case (code)
      2'h0: bist_len = 12'h408;
      2'h1: bist_len = 12'h7FF;
      2'h2: bist_len = 12'hBFF;
      2'h3: bist_len = 12'hFFF;
    endcase
  endfunction

  function automatic logic [15:0] lock_target(input logic [2:0] code);
    unique case (code)
      3'h0: lock_target = 16'h0005;
      3'h1: lock_target = 16'h0020;
      3'h2: lock_target = 16'h0060;
      3'h3: lock_target = 16'h0100;
      3'h4: lock_target = 16'h0200;
      3'h5: lock_target = 16'h0800;
      3'h6: lock_target = 16'h2000;
      3'h7: lock_target = 16'hFFFF;
    endcase
  endfunction

  // window length in timer ticks; zero means the half-cycle window
  function automatic logic [6:0] win_len(input logic [2:0] code);
    unique case (code)
      3'h0: win_len = 7'h00;
      3'h1: win_len = 7'h01;
      3'h2: win_len = 7'h02;
      3'h3: win_len = 7'h04;
      3'h4: win_len = 7'h08;
      3'h5: win_len = 7'h10;
      3'h6: win_len = 7'h20;
      3'h7: win_len = 7'h40;
    endcase
  endfunction

  // timer prescaler terminal value, fastest to slowest
  function automatic logic [2:0] presc_max(input logic [1:0] code);
    unique case (code)
      2'h0: presc_max = 3'h0;
      2'h1: presc_max = 3'h1;
      2'h2: presc_max = 3'h3;
      2'h3: presc_max = 3'h7;
    endcase
  endfunction

endpackage

// file: sdmlk_core_if.sv
// carrier between the top, the modulator and the lock detector
interface sdmlk_core_if;
  import sdmlk_pkg::*;

  // ==========================================================
  // modulator group
  logic step;
  logic clear;
  logic seed_load;
  logic [23:0] seed_value;
  logic [1:0] order;
  logic bypass;
  logic [23:0] frac_value;
  logic [18:0] intg_value;
  logic signed [2:0] offset;
  logic [19:0] div_value;

  // ==========================================================
  // lock detector group
  logic ref_ev;
  logic vco_ev;
  logic win_in;
  logic ld_enable;
  logic [2:0] wincnt_code;
  logic win_digital;
  logic [2:0] win_dur;
  logic [1:0] tmr_freq;
  logic tmr_test;
  logic relock_en;
  logic locked;
  logic relock_req;

  modport top_mp(
    output step, clear, seed_load, seed_value, order, bypass, frac_value, intg_value,
    output ref_ev, vco_ev, win_in, ld_enable, wincnt_code, win_digital, win_dur,
    output tmr_freq, tmr_test, relock_en,
    input offset, div_value, locked, relock_req
  );
  modport mod_mp(
    input step, clear, seed_load, seed_value, order, bypass, frac_value, intg_value,
    output offset, div_value
  );
  modport ld_mp(
    input ref_ev, vco_ev, win_in, ld_enable, wincnt_code, win_digital, win_dur,
    input tmr_freq, tmr_test, relock_en,
    output locked, relock_req
  );
endinterface

// file: sdmlk_modulator.sv
// delta-sigma accumulator pair and divide value output
module sdmlk_modulator
  import sdmlk_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // core signals
  sdmlk_core_if.mod_mp core
);

  typedef struct packed {
    logic [23:0] acc1;
    logic [23:0] acc2;
    logic c2_prev;
    logic signed [2:0] offset;
    logic [19:0] div;
  } sdmlk_mod_state_type;

  sdmlk_mod_state_type state_reg, state_next;
  logic [24:0] sum1;
  logic [24:0] sum2;

  // ==========================================================
  // accumulators
  always_comb begin
    state_next = state_reg;
    sum1 = {1'b0, state_reg.acc1} + {1'b0, core.frac_value}; // R20
    sum2 = {1'b0, state_reg.acc2} + {1'b0, sum1[23:0]};
    if (core.clear) begin
      state_next.acc1 = 24'h000000;
      state_next.acc2 = 24'h000000;
      state_next.c2_prev = 1'b0;
      state_next.offset = 3'sh0;
    end else if (core.seed_load) begin
      state_next.acc1 = core.seed_value; // R2
      state_next.acc2 = 24'h000000;
      state_next.c2_prev = 1'b0;
    end else if (core.step) begin
      state_next.acc1 = sum1[23:0];
      unique case (sdmlk_order_type'(core.order)) // R3
        SDMLK_ORD_FIRST, SDMLK_ORD_T1B: begin
          state_next.offset = {2'b00, sum1[24]};
        end
        SDMLK_ORD_SECOND, SDMLK_ORD_T2A: begin
          state_next.acc2 = sum2[23:0];
          state_next.c2_prev = sum2[24];
          state_next.offset = {2'b00, sum1[24]} + {2'b00, sum2[24]} - {2'b00, state_reg.c2_prev};
        end
      endcase
    end
    if (core.bypass) begin
      state_next.div = {1'b0, core.intg_value}; // R4
    end else begin
      state_next.div = {1'b0, core.intg_value} + {{17{state_reg.offset[2]}}, state_reg.offset};
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign core.offset = state_reg.offset;
  assign core.div_value = state_reg.div;

  // ==========================================================
  // checks
  property p_bypass_integer;
    @(posedge clock_i) disable iff (rst_i)
    core.bypass |=> (core.div_value == {1'b0, $past(core.intg_value)});
  endproperty
  a_bypass_integer: assert property (p_bypass_integer) // R4
    else $error("bypass did not give the integer divide value");

  property p_seed_loaded;
    @(posedge clock_i) disable iff (rst_i)
    (core.seed_load && !core.clear) |=> (state_reg.acc1 == $past(core.seed_value));
  endproperty
  a_seed_loaded: assert property (p_seed_loaded) // R6
    else $error("seed was not loaded into the accumulator");

endmodule // sdmlk_modulator

// file: sdmlk_lock_det.sv
// digital lock detector with window timer and single relock
module sdmlk_lock_det
  import sdmlk_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // core signals
  sdmlk_core_if.ld_mp core
);

  typedef struct packed {
    sdmlk_ld_phase_type phase;
    logic [2:0] presc;
    logic [6:0] timer;
    logic [15:0] count;
    logic locked;
    logic tried;
    logic relock;
  } sdmlk_ld_state_type;

  sdmlk_ld_state_type state_reg, state_next;
  logic hit;
  logic miss;
  logic tick;
  logic [15:0] cnt_inc;

  always_comb begin
    state_next = state_reg;
    state_next.relock = 1'b0;
    hit = 1'b0;
    miss = 1'b0;
    tick = (state_reg.presc == presc_max(core.tmr_freq)); // R17
    cnt_inc = (state_reg.count == LOCK_CNT_MAX) ? LOCK_CNT_MAX : state_reg.count + 16'h0001;
    // prescaler runs only while a window is open, or always in test mode
    if (core.tmr_test || state_reg.phase == SDMLK_LD_OPEN) begin // R18
      state_next.presc = tick ? 3'h0 : state_reg.presc + 3'h1;
    end else begin
      state_next.presc = 3'h0;
    end
    if (!core.ld_enable) begin
      state_next.phase = SDMLK_LD_IDLE;
      state_next.count = 16'h0000;
      state_next.locked = 1'b0;
    end else if (!core.win_digital) begin // R15
      if (core.vco_ev) begin
        hit = core.win_in;
        miss = !core.win_in;
      end
    end else begin
      unique case (state_reg.phase)
        SDMLK_LD_IDLE: begin
          if (core.ref_ev && core.vco_ev) begin
            hit = 1'b1;
          end else if (core.ref_ev || core.vco_ev) begin
            state_next.phase = SDMLK_LD_OPEN;
            state_next.timer = 7'h00;
          end
        end
        SDMLK_LD_OPEN: begin
          if (core.ref_ev || core.vco_ev) begin
            state_next.phase = SDMLK_LD_IDLE;
            hit = (state_reg.timer < win_len(core.win_dur)); // R16
            miss = !hit;
          end else if (state_reg.timer >= win_len(core.win_dur)) begin
            state_next.phase = SDMLK_LD_IDLE;
            miss = 1'b1;
          end else if (tick) begin
            state_next.timer = state_reg.timer + 7'h01;
          end
        end
      endcase
    end
    if (hit) begin
      state_next.count = cnt_inc;
      if (cnt_inc >= lock_target(core.wincnt_code)) begin // R14
        state_next.locked = 1'b1;
      end
    end
    if (miss) begin
      state_next.count = 16'h0000; // R21
      state_next.locked = 1'b0;
      if (state_reg.locked && core.relock_en && !state_reg.tried) begin // R19
        state_next.relock = 1'b1;
        state_next.tried = 1'b1;
      end
    end
    if (!core.relock_en) begin
      state_next.tried = 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign core.locked = state_reg.locked;
  assign core.relock_req = state_reg.relock;

  // ==========================================================
  // checks
  property p_miss_clears;
    @(posedge clock_i) disable iff (rst_i)
    miss |=> (!core.locked && state_reg.count == 16'h0000);
  endproperty
  a_miss_clears: assert property (p_miss_clears) // R21
    else $error("miss did not clear the tally and lock");

  property p_lock_after_count;
    @(posedge clock_i) disable iff (rst_i)
    $rose(core.locked) |-> $past(hit) && (state_reg.count >= lock_target($past(core.wincnt_code)));
  endproperty
  a_lock_after_count: assert property (p_lock_after_count) // R14
    else $error("lock declared before the programmed count");

  property p_single_relock;
    @(posedge clock_i) disable iff (rst_i)
    (state_reg.tried && $past(state_reg.tried)) |-> !core.relock_req;
  endproperty
  a_single_relock: assert property (p_single_relock) // R19
    else $error("second relock attempt issued");

endmodule // sdmlk_lock_det

// file: sdmlk_top_test.sv
// self-checking bench of the modulator config and lock detect top
module sdmlk_top_test;
  import sdmlk_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, rst_i = 1, reg_wr_i = 0, intg_write_i = 0, frac_write_i = 0;
  logic analog_win_i = 0, mod_rstb_i = 1;
  logic [4:0] reg_addr_i = 0;
  logic [23:0] reg_wdata_i = 0, frac_value_i = 0, reg_rdata_o, d;
  logic [18:0] intg_value_i = 0;
  logic [3:0] ck = 0;
  logic [19:0] div_value_o;
  logic [1:0] mod_clk_src_o;
  logic [15:0] self_test_sig_o;
  logic frac_core_en_o, cal_start_o, lock_detect_o, relock_o, self_test_busy_o, self_test_done_o;
  int n_fail = 0, num_checks = 0, n_relock = 0, n;
  sdmlk_top dut (.clock_i(clock_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .intg_value_i(intg_value_i),
    .frac_value_i(frac_value_i), .intg_write_i(intg_write_i), .frac_write_i(frac_write_i),
    .ref_div_clk_i(ck[0]), .vco_div_clk_i(ck[1]), .vco_dly_clk_i(ck[2]), .aux_clk_i(ck[3]),
    .analog_win_i(analog_win_i), .mod_rstb_i(mod_rstb_i), .div_value_o(div_value_o),
    .frac_core_en_o(frac_core_en_o), .mod_clk_src_o(mod_clk_src_o), .cal_start_o(cal_start_o),
    .lock_detect_o(lock_detect_o), .relock_o(relock_o), .self_test_busy_o(self_test_busy_o),
    .self_test_done_o(self_test_done_o), .self_test_sig_o(self_test_sig_o));
  always #10 clock_i = ~clock_i;
  always @(posedge clock_i) if (relock_o === 1'b1) n_relock++;
  // ==========================================================
  // tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [23:0] v);
    @(posedge clock_i) #1;
    reg_wr_i = 1;
    reg_addr_i = a;
    reg_wdata_i = v;
    @(posedge clock_i) #1;
    reg_wr_i = 0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [23:0] exp);
    @(posedge clock_i) #1;
    reg_addr_i = a;
    @(posedge clock_i) #1;
    chk(reg_rdata_o, exp);
  endtask
  task automatic tick(input logic [3:0] m);
    ck = m;
    repeat (3) @(posedge clock_i);
    #1 ck = 4'h0;
    repeat (3) @(posedge clock_i);
    #1;
  endtask
  function automatic logic [1:0] src_of(input logic [23:0] v);
    return v[10] ? 2'h2 : v[21] ? 2'h3 : v[9] ? 2'h1 : 2'h0;
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #1_500_000;
    n_fail++;
    close_out;
  end
  // ==========================================================
  // tests
  initial begin
    void'($urandom(44));
    repeat (6) @(posedge clock_i);
    #1 rst_i = 0;
    rd(MCFG_ADDR, MCFG_RESET);
    rd(LCFG_ADDR, LCFG_RESET);
    rd(5'h1F, 24'h000000);
    for (int k = 0; k < 10; k++) begin
      // corner cases: delayed, auto override, vco divider, reference divider
      d = (k == 0) ? 24'h000E00 : (k == 1) ? 24'h200300 : (k == 2) ? 24'h000380
        : (k == 3) ? 24'h0001C0 : 24'($urandom);
      wr(MCFG_ADDR, d);
      rd(MCFG_ADDR, d);
      chk(24'(mod_clk_src_o), 24'(src_of(d)));
      chk(24'(frac_core_en_o), 24'(d[11]));
      frac_write_i = 1;
      #1 chk(24'(cal_start_o), 24'(d[11]));
      @(posedge clock_i) #1;
      frac_write_i = 0;
      intg_write_i = 1;
      #1 chk(24'(cal_start_o), 24'(!d[11]));
      @(posedge clock_i) #1;
      intg_write_i = 0;
    end
    wr(MCFG_ADDR, 24'h000880);
    intg_value_i = 19'($urandom);
    repeat (3) @(posedge clock_i);
    #1 chk(24'(div_value_o), 24'(intg_value_i));
    // half-scale fraction, first order, zero seed: carry on every second step
    wr(MCFG_ADDR, 24'h000900);
    frac_value_i = 24'h800000;
    frac_write_i = 1;
    @(posedge clock_i) #1;
    frac_write_i = 0;
    for (int s = 0; s < 2; s++) begin
      tick(4'h1);
      chk(24'(div_value_o), 24'(intg_value_i) + 24'(s));
    end
    wr(MCFG_ADDR, 24'h040000);
    n = 0;
    while (self_test_done_o !== 1'b1 && n < 1100) begin
      tick(4'h1);
      n++;
      if (n == 1) chk(24'(self_test_busy_o), 24'h000001);
    end
    chk(24'(n), 24'h000408);
    chk(24'(self_test_busy_o), 24'h000000);
    chk(24'(self_test_sig_o), 24'h00FFFF);
    wr(LCFG_ADDR, 24'h002008);
    for (int r = 0; r < 2; r++) begin
      analog_win_i = 1;
      repeat (4) tick(4'h2);
      chk(24'(lock_detect_o), 24'h000000);
      tick(4'h2);
      chk(24'(lock_detect_o), 24'h000001);
      analog_win_i = 0;
      tick(4'h2);
      chk(24'(lock_detect_o), 24'h000000);
    end
    chk(24'(n_relock), 24'h000001);
    // digital half-cycle window: only coincident edges land inside
    wr(LCFG_ADDR, 24'h000048);
    repeat (5) tick(4'h3);
    chk(24'(lock_detect_o), 24'h000001);
    tick(4'h2);
    chk(24'(lock_detect_o), 24'h000000);
    close_out;
  end
endmodule // sdmlk_top_test
